// ==== include/cfl_pkg.sv ====
package cfl_pkg;
  // table count and widths
  localparam int NUM_TABLES  = 2;
  localparam int SEL_W       = 3;
  localparam int PATTERN_W   = 8;
  localparam int FILT_W      = 2;
  localparam int SEQ_W       = 3;
  localparam int SYNC_STAGES = 3;
  localparam int FILT_TAPS   = 4;

  // input source select codes
  localparam logic [2:0] SRC_MASK     = 3'h0;
  localparam logic [2:0] SRC_FEEDBACK = 3'h1;
  localparam logic [2:0] SRC_LINK     = 3'h2;
  localparam logic [2:0] SRC_EVENT0   = 3'h3;
  localparam logic [2:0] SRC_EVENT1   = 3'h4;
  localparam logic [2:0] SRC_IO       = 3'h5;
  localparam logic [2:0] SRC_AC       = 3'h6;
  localparam logic [2:0] SRC_TC       = 3'h7;

  // output stage options
  localparam logic [1:0] FILT_OFF     = 2'h0;
  localparam logic [1:0] FILT_SYNC    = 2'h1;
  localparam logic [1:0] FILT_FILTER  = 2'h2;

  // sequencer function codes
  localparam logic [2:0] SEQ_OFF      = 3'h0;
  localparam logic [2:0] SEQ_DFF      = 3'h1;
  localparam logic [2:0] SEQ_JK       = 3'h2;
  localparam logic [2:0] SEQ_DLATCH   = 3'h3;
  localparam logic [2:0] SEQ_RS       = 3'h4;

  // reset values
  localparam logic [2:0] RST_SEL      = 3'h0;
  localparam logic [7:0] RST_PATTERN  = 8'h00;
  localparam logic [1:0] RST_FILT     = 2'h0;
  localparam logic [2:0] RST_SEQ      = 3'h0;
endpackage : cfl_pkg

// ==== include/cfl_tbl_if.sv ====
`timescale 1ns/10ps
interface cfl_tbl_if;
  logic [1:0]      active;
  logic [1:0]      tick;
  logic [1:0]      raw;
  logic [1:0]      edge_en;
  logic [1:0][1:0] filt_sel;
  logic [1:0]      result;
  logic [2:0]      seq_mode;
  logic            seq_q;

  modport ctrl (output active, tick, raw, edge_en, filt_sel, seq_mode, input result, seq_q);
  modport filt (input active, tick, raw, edge_en, filt_sel, output result);
  modport seq  (input active, tick, result, seq_mode, output seq_q);
endinterface : cfl_tbl_if

// ==== design/cfl_out_stage.sv ====
`timescale 1ns/10ps
module cfl_out_stage (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  // table side
  cfl_tbl_if.filt   tbl
);

  typedef struct packed {
    logic [1:0][cfl_pkg::FILT_TAPS-1:0] taps;
    logic [1:0]                         filt;
    logic [1:0]                         prev;
  } cfl_stage_type;

  cfl_stage_type st_ff;
  cfl_stage_type nxt_st;
  logic [1:0]    level;

  always_comb begin
    nxt_st = st_ff;
    for (int n = 0; n < 2; n++) begin
      if (!tbl.active[n]) begin
        // whole stage cleared on the cycle after disable
        nxt_st.taps[n] = '0;
        nxt_st.filt[n] = 1'b0;
        nxt_st.prev[n] = 1'b0;
      end else if (tbl.tick[n]) begin
        nxt_st.taps[n] = {st_ff.taps[n][cfl_pkg::FILT_TAPS-2:0], tbl.raw[n]};
        // three agreeing samples after two sync taps: 4..5 ticks late
        if (st_ff.taps[n][1] == st_ff.taps[n][2] && st_ff.taps[n][2] == st_ff.taps[n][3]) begin
          nxt_st.filt[n] = st_ff.taps[n][3];
        end
        nxt_st.prev[n] = level[n];
      end
    end
  end

  always_comb begin
    for (int n = 0; n < 2; n++) begin
      if (tbl.filt_sel[n] == cfl_pkg::FILT_SYNC) begin
        level[n] = st_ff.taps[n][1];
      end else if (tbl.filt_sel[n] == cfl_pkg::FILT_FILTER) begin
        level[n] = st_ff.filt[n];
      end else begin
        level[n] = tbl.raw[n];
      end
      // edge pulse only meaningful with a filter in front of it
      tbl.result[n] = tbl.active[n] & (tbl.edge_en[n] ? (level[n] & ~st_ff.prev[n]) : level[n]);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : cfl_out_stage

// ==== design/cfl_sequencer.sv ====
`timescale 1ns/10ps
module cfl_sequencer (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  // table side
  cfl_tbl_if.seq    tbl
);

  typedef struct packed {
    logic q;
  } cfl_seq_type;

  cfl_seq_type st_ff;
  cfl_seq_type nxt_st;
  logic        even_in;
  logic        odd_in;

  always_comb begin
    nxt_st  = st_ff;
    even_in = tbl.result[0];
    odd_in  = tbl.result[1];
    if (!tbl.active[0]) begin
      nxt_st.q = 1'b0;
    end else begin
      case (tbl.seq_mode)
        cfl_pkg::SEQ_DFF: begin
          if (tbl.tick[0] && odd_in) begin
            nxt_st.q = even_in;
          end
        end
        cfl_pkg::SEQ_JK: begin
          if (tbl.tick[0]) begin
            case ({even_in, odd_in})
              2'h1:    nxt_st.q = 1'b0;
              2'h2:    nxt_st.q = 1'b1;
              2'h3:    nxt_st.q = ~st_ff.q;
              default: nxt_st.q = st_ff.q;
            endcase
          end
        end
        cfl_pkg::SEQ_DLATCH: begin
          // level sensitive, so it follows every system cycle
          if (odd_in) begin
            nxt_st.q = even_in;
          end
        end
        cfl_pkg::SEQ_RS: begin
          // forbidden 1/1 simply holds
          if (even_in && !odd_in) begin
            nxt_st.q = 1'b1;
          end else if (!even_in && odd_in) begin
            nxt_st.q = 1'b0;
          end
        end
        default: nxt_st.q = 1'b0;
      endcase
    end
  end

  // clear is seen at once while the register catches up
  assign tbl.seq_q = st_ff.q & tbl.active[0];

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : cfl_sequencer

// ==== design/cfl_top.sv ====
`timescale 1ns/10ps
module cfl_top (
  // clock and reset
  input  wire logic            sys_clk_i,
  input  wire logic            reset_n_i,
  // global control
  input  wire logic            global_control_wr_i,
  input  wire logic            global_enable_i,
  // table control first
  input  wire logic [1:0]      table_control_first_wr_i,
  input  wire logic [1:0]      table_enable_i,
  input  wire logic [1:0]      table_clock_source_select_i,
  input  wire logic [1:0][1:0] filter_select_i,
  input  wire logic [1:0]      edge_detect_i,
  // table control second and third
  input  wire logic [1:0]      table_control_second_wr_i,
  input  wire logic [1:0][2:0] input_zero_source_select_i,
  input  wire logic [1:0][2:0] input_one_source_select_i,
  input  wire logic [1:0]      table_control_third_wr_i,
  input  wire logic [1:0][2:0] input_two_source_select_i,
  // patterns
  input  wire logic [1:0]      pattern_wr_i,
  input  wire logic [1:0][7:0] pattern_i,
  // sequencer control
  input  wire logic            sequencer_control_wr_i,
  input  wire logic [2:0]      sequencer_function_select_i,
  // signal sources
  input  wire logic [1:0][2:0] table_input_pins_i,
  input  wire logic [1:0]      event_in_i,
  input  wire logic            comparator_i,
  input  wire logic [2:0]      timer_wave_i,
  // outputs
  output logic      [1:0]      table_output_pin_o,
  output logic      [1:0]      table_event_o,
  output logic                 sequencer_output_o,
  output logic                 block_enabled_o,
  output logic      [1:0]      table_enabled_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic                                     glob_en;
    logic [1:0]                               tbl_en;
    logic [1:0]                               clk_src;
    logic [1:0][1:0]                          filt_sel;
    logic [1:0]                               edge_en;
    logic [1:0][2:0]                          sel0;
    logic [1:0][2:0]                          sel1;
    logic [1:0][2:0]                          sel2;
    logic [1:0][7:0]                          pattern;
    logic [2:0]                               seq_mode;
    logic [1:0][2:0][cfl_pkg::SYNC_STAGES-1:0] pin_s;
    logic [1:0][2:0]                          pin_v;
    logic [1:0][cfl_pkg::SYNC_STAGES-1:0]     evt_s;
    logic [1:0]                               evt_v;
    logic [1:0]                               in2_prev;
    logic [1:0]                               out;
    logic                                     seq_out;
  } cfl_top_type;

  cfl_top_type     st_ff;
  cfl_top_type     nxt_st;
  logic [1:0]      rst_sync_ff;
  logic            rst_n;
  logic [1:0][2:0] in_val;
  logic [1:0]      in2_clk;
  logic [1:0]      tick;
  logic [1:0]      active;
  logic [1:0]      lut_raw;

  cfl_tbl_if tbl_if ();

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic cfl_lookup(input logic [7:0] pat, input logic [2:0] idx);
    logic bit_val;
    bit_val = pat[idx];
    return bit_val;
  endfunction : cfl_lookup

  function automatic logic cfl_source(
    input logic [2:0] sel,
    input logic       feedback,
    input logic       link,
    input logic [1:0] evt,
    input logic       pin,
    input logic       ac,
    input logic       tc
  );
    logic val;
    val = 1'b0;
    if (sel == cfl_pkg::SRC_FEEDBACK) begin
      val = feedback;
    end else if (sel == cfl_pkg::SRC_LINK) begin
      val = link;
    end else if (sel == cfl_pkg::SRC_EVENT0) begin
      val = evt[0];
    end else if (sel == cfl_pkg::SRC_EVENT1) begin
      val = evt[1];
    end else if (sel == cfl_pkg::SRC_IO) begin
      val = pin;
    end else if (sel == cfl_pkg::SRC_AC) begin
      val = ac;
    end else if (sel == cfl_pkg::SRC_TC) begin
      val = tc;
    end
    return val;
  endfunction : cfl_source

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  ////////////////////////////////////////////////////////////////////////////
  // input routing and ticks

  always_comb begin
    for (int n = 0; n < 2; n++) begin
      // link from the other table's registered output keeps loops out
      for (int k = 0; k < 3; k++) begin
        logic [2:0] sel;
        sel = (k == 0) ? st_ff.sel0[n] : ((k == 1) ? st_ff.sel1[n] : st_ff.sel2[n]);
        in_val[n][k] = cfl_source(sel, tbl_if.seq_q, st_ff.out[1 - n], st_ff.evt_v,
                                  st_ff.pin_v[n][k], comparator_i, timer_wave_i[k]);
      end
      in2_clk[n] = in_val[n][2];
      active[n]  = st_ff.glob_en & st_ff.tbl_en[n];
      // no halt input at all, so debug stops nothing
      tick[n]    = st_ff.clk_src[n] ? (in2_clk[n] & ~st_ff.in2_prev[n]) : 1'b1;
      lut_raw[n] = active[n] & cfl_lookup(st_ff.pattern[n],
                     {in_val[n][2] & ~st_ff.clk_src[n], in_val[n][1], in_val[n][0]});
    end
  end

  assign tbl_if.active   = active;
  assign tbl_if.tick     = tick;
  assign tbl_if.raw      = lut_raw;
  assign tbl_if.edge_en  = st_ff.edge_en;
  assign tbl_if.filt_sel = st_ff.filt_sel;
  assign tbl_if.seq_mode = st_ff.seq_mode;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    nxt_st = st_ff;

    // three stage sync, value moves once the last two agree
    for (int n = 0; n < 2; n++) begin
      for (int k = 0; k < 3; k++) begin
        nxt_st.pin_s[n][k] = {st_ff.pin_s[n][k][1:0], table_input_pins_i[n][k]};
        if (st_ff.pin_s[n][k][1] == st_ff.pin_s[n][k][2]) begin
          nxt_st.pin_v[n][k] = st_ff.pin_s[n][k][2];
        end
      end
      nxt_st.evt_s[n] = {st_ff.evt_s[n][1:0], event_in_i[n]};
      if (st_ff.evt_s[n][1] == st_ff.evt_s[n][2]) begin
        nxt_st.evt_v[n] = st_ff.evt_s[n][2];
      end
      nxt_st.in2_prev[n] = in2_clk[n];
    end

    // clock sources are guarded by each table's enable below, not by this block enable
    if (global_control_wr_i) begin
      nxt_st.glob_en = global_enable_i;
    end

    for (int n = 0; n < 2; n++) begin
      // protected fields only move while the table is still off
      if (table_control_first_wr_i[n]) begin
        nxt_st.tbl_en[n] = table_enable_i[n];
        if (!st_ff.tbl_en[n]) begin
          nxt_st.clk_src[n]  = table_clock_source_select_i[n];
          nxt_st.filt_sel[n] = filter_select_i[n];
          nxt_st.edge_en[n]  = edge_detect_i[n];
        end
      end
      if (table_control_second_wr_i[n] && !st_ff.tbl_en[n]) begin
        nxt_st.sel0[n] = input_zero_source_select_i[n];
        nxt_st.sel1[n] = input_one_source_select_i[n];
      end
      if (table_control_third_wr_i[n] && !st_ff.tbl_en[n]) begin
        nxt_st.sel2[n] = input_two_source_select_i[n];
      end
      if (pattern_wr_i[n] && !st_ff.tbl_en[n]) begin
        nxt_st.pattern[n] = pattern_i[n];
      end
    end

    if (sequencer_control_wr_i && !st_ff.tbl_en[0]) begin
      nxt_st.seq_mode = sequencer_function_select_i;
    end

    // registered outputs cost one cycle but keep pins glitch free
    nxt_st.out     = tbl_if.result;
    nxt_st.seq_out = tbl_if.seq_q;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output stage and sequencer

  cfl_out_stage u_out_stage (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n),
    .tbl       (tbl_if.filt)
  );

  cfl_sequencer u_sequencer (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n),
    .tbl       (tbl_if.seq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign table_output_pin_o = st_ff.out;
  assign table_event_o      = st_ff.out;
  assign sequencer_output_o = st_ff.seq_out;
  assign block_enabled_o    = st_ff.glob_en;
  assign table_enabled_o    = st_ff.tbl_en;

endmodule : cfl_top

// ==== sim/cfl_src_model.sv ====
`timescale 1ns/10ps
module cfl_src_model (
  // stimulus word
  input  wire logic [7:0]      stim_i,
  // source lines
  output logic                 comparator_o,
  output logic      [2:0]      timer_wave_o,
  output logic      [1:0]      event_o,
  output logic      [1:0][2:0] pins_o
);
  ////////////////////////////////////////////////////////////////////////////
  // every source moves with the stimulus word, so none stays frozen
  always_comb begin
    comparator_o = stim_i[0];
    timer_wave_o = stim_i[3:1];
    event_o      = stim_i[5:4];
    pins_o       = {stim_i[7:5], ~stim_i[2:0]};
  end
endmodule : cfl_src_model

// ==== sim/cfl_top_assertions.sv ====
`timescale 1ns/10ps
module cfl_top_assertions (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  // control
  input  wire logic       global_control_wr_i,
  input  wire logic       global_enable_i,
  input  wire logic [1:0] table_control_first_wr_i,
  input  wire logic [1:0] table_enable_i,
  // outputs
  input  wire logic [1:0] table_output_pin_o,
  input  wire logic [1:0] table_event_o,
  input  wire logic       sequencer_output_o,
  input  wire logic       block_enabled_o,
  input  wire logic [1:0] table_enabled_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  ////////////////////////////////////////////////////////////////////////////
  // margins of six (block) and three (even table) cycles cover output register and filter clear
  sequence s_block_off;
    (!block_enabled_o)[*6];
  endsequence
  sequence s_even_off;
    (!table_enabled_o[0])[*3];
  endsequence

  a_pin_event_equal: assert property (table_event_o == table_output_pin_o)
    else $error("table event differs from table pin");
  a_global_gate: assert property (s_block_off |-> table_output_pin_o == 2'h0)
    else $error("output active while block off");
  a_table_gate: assert property ((!table_enabled_o[0])[*6] |-> !table_output_pin_o[0])
    else $error("table output active while table off");
  a_global_follow: assert property (global_control_wr_i |=> block_enabled_o == $past(global_enable_i))
    else $error("block enable did not follow write");
  a_enable_follow: assert property (table_control_first_wr_i[0] |=>
    table_enabled_o[0] == $past(table_enable_i[0]))
    else $error("table enable did not follow write");
  a_status_hold: assert property (!global_control_wr_i |=> $stable(block_enabled_o))
    else $error("block enable moved without write");
  a_seq_cleared: assert property (s_even_off |-> !sequencer_output_o)
    else $error("sequencer set while even table off");
  a_reset_quiet: assert property ($rose(reset_n_i) |->
    (block_enabled_o == 1'b0 && table_output_pin_o == 2'h0)[*3])
    else $error("outputs active after reset release");
endmodule : cfl_top_assertions

// ==== sim/configurable_lookup_logic_test.sv ====
`timescale 1ns/10ps
module configurable_lookup_logic_test;
  logic            sys_clk_i;
  logic            reset_n_i;
  logic            global_control_wr_i;
  logic            global_enable_i;
  logic [1:0]      table_control_first_wr_i;
  logic [1:0]      table_enable_i;
  logic [1:0]      table_control_second_wr_i;
  logic [1:0]      table_control_third_wr_i;
  logic [1:0][2:0] input_zero_source_select_i;
  logic [1:0][2:0] input_one_source_select_i;
  logic [1:0][2:0] input_two_source_select_i;
  logic [1:0]      pattern_wr_i;
  logic [1:0][7:0] pattern_i;
  logic            sequencer_control_wr_i;
  logic [2:0]      sequencer_function_select_i;
  logic [1:0][2:0] table_input_pins_i;
  logic [1:0]      event_in_i;
  logic            comparator_i;
  logic [2:0]      timer_wave_i;
  logic [1:0]      table_output_pin_o;
  logic [1:0]      table_event_o;
  logic            sequencer_output_o;
  logic            block_enabled_o;
  logic [1:0]      table_enabled_o;
  logic [7:0]      stim;
  logic [15:0]     seed;
  int              pat;
  int              exp_v;
  int              exp_q[$];
  int              n_fail;
  int              total_checks;
  int              cycles;

  ////////////////////////////////////////////////////////////////////////////
  // design and far side
  cfl_top uut (.sys_clk_i, .reset_n_i, .global_control_wr_i, .global_enable_i, .table_control_first_wr_i,
    .table_enable_i, .table_clock_source_select_i(2'h0), .filter_select_i(4'h0), .edge_detect_i(2'h0),
    .table_control_second_wr_i, .input_zero_source_select_i, .input_one_source_select_i,
    .table_control_third_wr_i, .input_two_source_select_i, .pattern_wr_i, .pattern_i,
    .sequencer_control_wr_i, .sequencer_function_select_i, .table_input_pins_i, .event_in_i,
    .comparator_i, .timer_wave_i, .table_output_pin_o, .table_event_o, .sequencer_output_o,
    .block_enabled_o, .table_enabled_o);
  cfl_src_model far_side (.stim_i(stim), .comparator_o(comparator_i), .timer_wave_o(timer_wave_i),
    .event_o(event_in_i), .pins_o(table_input_pins_i));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  // hang guard, far above the few hundred cycles needed
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      wrap_up();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  task automatic chk(input string nm, input logic [1:0] e, input logic [1:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  // strobes: global, first, second, third, pattern of table 0
  task automatic strobe(input logic [4:0] w);
    @(negedge sys_clk_i);
    {global_control_wr_i, table_control_first_wr_i[0], table_control_second_wr_i[0],
      table_control_third_wr_i[0], pattern_wr_i[0]} = w;
    @(negedge sys_clk_i);
    {global_control_wr_i, table_control_first_wr_i, table_control_second_wr_i,
      table_control_third_wr_i, pattern_wr_i} = 9'h000;
  endtask : strobe

  // input 0 is comparator, inputs 1 and 2 are timer bits 1 and 2
  task automatic run(input int n, input int m1, input int on);
    int idx;
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      stim = seed[7:0];
      idx = {stim[3], stim[2] & (m1 == 0), stim[0]};
      exp_q.push_back(on * ((pat >> idx) & 1));
      repeat (3) @(negedge sys_clk_i);
      exp_v = exp_q.pop_front();
      chk("pin", {1'b0, exp_v[0]}, table_output_pin_o);
      chk("event", {1'b0, exp_v[0]}, table_event_o);
    end
  endtask : run

  // one pulse on the sequencer function strobe
  task automatic seq_write(input logic [2:0] f);
    @(negedge sys_clk_i);
    sequencer_function_select_i = f;
    sequencer_control_wr_i = 1'b1;
    @(negedge sys_clk_i);
    sequencer_control_wr_i = 1'b0;
  endtask : seq_write

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {global_control_wr_i, global_enable_i, table_control_first_wr_i, table_enable_i} = 6'h00;
    {table_control_second_wr_i, table_control_third_wr_i, pattern_wr_i, pattern_i} = 22'h000000;
    {input_zero_source_select_i, input_one_source_select_i, input_two_source_select_i} = 18'h00000;
    {n_fail, total_checks, cycles} = 0;
    sequencer_control_wr_i = 1'b0;
    sequencer_function_select_i = 3'h0;
    reset_n_i = 1'b0;
    seed = 16'hCBCE;
    stim = 8'h00;
    repeat (16) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    chk("table status", 2'h0, table_enabled_o);
    chk("block status", 2'h0, {1'b0, block_enabled_o});
    chk("sequencer", 2'h0, {1'b0, sequencer_output_o});
    seed = lfsr(seed);
    pat = seed[7:0];
    input_zero_source_select_i[0] = cfl_pkg::SRC_AC;
    input_one_source_select_i[0] = cfl_pkg::SRC_TC;
    input_two_source_select_i[0] = cfl_pkg::SRC_TC;
    pattern_i[0] = pat[7:0];
    table_enable_i[0] = 1'b1;
    strobe(5'h06);
    strobe(5'h09);
    chk("table status", 2'h1, table_enabled_o);
    global_enable_i = 1'b1;
    strobe(5'h10);
    chk("block status", 2'h1, {1'b0, block_enabled_o});
    run(20, 0, 1);
    // writes while enabled must bounce off
    pattern_i[0] = ~pat[7:0];
    input_one_source_select_i[0] = cfl_pkg::SRC_MASK;
    strobe(5'h05);
    run(8, 0, 1);
    table_enable_i[0] = 1'b0;
    strobe(5'h08);
    run(6, 0, 0);
    strobe(5'h04);
    table_enable_i[0] = 1'b1;
    strobe(5'h08);
    run(12, 1, 1);
    global_enable_i = 1'b0;
    strobe(5'h10);
    run(8, 1, 0);
    // function write while table 0 is on must bounce off
    seq_write(cfl_pkg::SEQ_RS);
    global_enable_i = 1'b1;
    strobe(5'h10);
    run(8, 1, 1);
    chk("sequencer", 2'h0, {1'b0, sequencer_output_o});
    table_enable_i[0] = 1'b0;
    strobe(5'h08);
    pattern_i[0] = 8'hFF;
    strobe(5'h01);
    seq_write(cfl_pkg::SEQ_RS);
    table_enable_i[0] = 1'b1;
    strobe(5'h08);
    repeat (3) @(negedge sys_clk_i);
    chk("pin", 2'h1, table_output_pin_o);
    chk("sequencer", 2'h1, {1'b0, sequencer_output_o});
    table_enable_i[0] = 1'b0;
    strobe(5'h08);
    repeat (3) @(negedge sys_clk_i);
    chk("sequencer", 2'h0, {1'b0, sequencer_output_o});
    wrap_up();
  end
endmodule : configurable_lookup_logic_test

bind cfl_top cfl_top_assertions chk_i (.sys_clk_i, .reset_n_i, .global_control_wr_i, .global_enable_i,
  .table_control_first_wr_i, .table_enable_i, .table_output_pin_o, .table_event_o, .sequencer_output_o,
  .block_enabled_o, .table_enabled_o);
